// ### hw/semc_cfg.svh
// Offsets, field positions, reset values and counts of the sensor enable/mode block
`ifndef SEMC_CFG_SVH
`define SEMC_CFG_SVH

// Register byte offsets
`define SEMC_MODE_CONFIG_OFS   8'h70
`define SEMC_LED_CONTROL_OFS   8'h74
`define SEMC_ENABLE_CONTROL_OFS 8'h80
`define SEMC_WAIT_TIME_OFS     8'h88
`define SEMC_STATUS_OFS        8'h8c

// Reset values
`define SEMC_MODE_CONFIG_RST   8'h00
`define SEMC_LED_CONTROL_RST   8'h04
`define SEMC_ENABLE_CONTROL_RST 8'h00
`define SEMC_WAIT_TIME_RST     8'h00

// enable_control fields
`define SEMC_POWER_ON_BIT      0
`define SEMC_MEASURE_EN_BIT    1
`define SEMC_WAIT_GAP_EN_BIT   3
`define SEMC_MUX_START_BIT     4

// mode_config fields
`define SEMC_SENSE_MODE_LSB    0
`define SEMC_IRQ_SYNC_SEL_BIT  2
`define SEMC_LED_CTRL_SEL_BIT  3

// led_control fields
`define SEMC_LED_ACT_BIT       7

// Default timing counts, in clock cycles
`define SEMC_INTEG_CYCLES      100
`define SEMC_WAIT_UNIT_CYCLES  16
`define SEMC_MUX_CYCLES        32

`endif

// ### hw/semc_pkg.sv
// Types shared by the sensor enable/mode block
package semc_pkg;

    // Measurement sequencer states
    typedef enum logic [1:0] {
        SEMC_IDLE  = 2'b00,
        SEMC_ARM   = 2'b01,
        SEMC_INTEG = 2'b10,
        SEMC_GAP   = 2'b11
    } semc_meas_state_t;

    // Sensing modes held in mode_config[1:0]
    typedef enum logic [1:0] {
        SEMC_PLAIN_MEASURE    = 2'b00,
        SEMC_SYNC_START       = 2'b01,
        SEMC_MODE_RESERVED    = 2'b10,
        SEMC_SYNC_START_STOP  = 2'b11
    } semc_sense_mode_t;

endpackage

// ### hw/semc_timer.sv
// Loadable down-counter that reports a one-cycle done pulse
`timescale 1ns/1ps
module semc_timer #(
    parameter int W = 16                // Counter width
) (
    input  wire logic         clk,      // System clock
    input  wire logic         rst_b,    // Asynchronous reset, active low
    input  wire logic         start,    // Load and start counting
    input  wire logic         abort,    // Stop without done
    input  wire logic [W-1:0] load,     // Cycles to run, at least one
    output logic              busy,     // Counting
    output logic              done      // One-cycle pulse at expiry
);
    logic [W-1:0] cnt;                  // Remaining cycles

    // Count down; start wins over abort and expiry
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt  <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            cnt  <= load;
            busy <= 1'b1;
            done <= 1'b0;
        end else if (abort) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else if (busy && cnt <= W'(1)) begin
            busy <= 1'b0;
            done <= 1'b1;
        end else begin
            cnt  <= busy ? cnt - W'(1) : cnt;
            done <= 1'b0;
        end
    end
endmodule // semc_timer

// ### hw/semc_top.sv
// Enable and mode configuration of a spectral sensor with an AHB-Lite register slave
//
// Contract
// R1: Host sets power-on before configuring and measuring.
// R2: Host avoids configuration changes while measuring.
// R3: Writing mux start launches the sensor mux command.
// R4: Mux start bit self-clears when command completes.
// R5: Wait gap enable inserts wait between measurements.
// R6: Measure enable starts and stops spectral measurement.
// R7: Power-on enables device and starts oscillator.
// R8: LED select lets LED register drive pin.
// R9: IRQ sync select turns irq pin into sync.
// R10: Sense mode selects plain, sync-start, sync-start-stop.
// R11: Host reads alternate data in sync-start-stop mode. The block has no alternate data register; unmapped reads return zero.
`timescale 1ns/1ps
`include "semc_cfg.svh"
module semc_top #(
    parameter int INTEG_CYCLES = `SEMC_INTEG_CYCLES,     // Integration length
    parameter int WAIT_UNIT    = `SEMC_WAIT_UNIT_CYCLES, // Cycles per wait step
    parameter int MUX_CYCLES   = `SEMC_MUX_CYCLES,       // Mux command length
    parameter int TW           = 16                      // Timer width
) (
    input  wire logic                        clk,          // System clock, 50 MHz
    input  wire logic                        rst_b,        // Asynchronous reset, active low
    input  wire logic                        hsel,         // AHB slave select
    input  wire logic [7:0]                  haddr,        // AHB byte address, low bits
    input  wire logic [1:0]                  htrans,       // AHB transfer type
    input  wire logic                        hwrite,       // AHB write
    input  wire logic [2:0]                  hsize,        // AHB size, word only
    input  wire logic [31:0]                 hwdata,       // AHB write data
    input  wire logic                        hready,       // AHB bus ready
    output logic [31:0]                      hrdata,       // AHB read data
    output logic                             hreadyout,    // AHB slave ready
    output logic                             hresp,        // AHB response, always OKAY
    input  wire logic                        sync_in,      // Dedicated sync pin
    input  wire logic                        irq_pin_in,   // Level seen on irq pin
    output logic                             irq_pin_out,  // Level driven on irq pin
    output logic                             irq_pin_oe,   // Irq pin driven
    input  wire logic                        irq_req,      // Interrupt request from sensor core
    output logic                             led_drive_pin,// LED on level
    output logic                             led_drive_oe, // LED pin controlled
    output logic [6:0]                       led_current,  // LED drive strength code
    output logic                             osc_enable,   // Internal oscillator on
    output logic                             meas_done,    // One-cycle end of integration
    output logic                             mux_busy,     // Mux command running
    output semc_pkg::semc_meas_state_t       meas_state    // Sequencer state
);
    import semc_pkg::*;

    // Software-visible registers
    logic [7:0] mode_config;            // Mode, sync and LED routing
    logic [7:0] led_control;            // LED on bit and strength
    logic [7:0] enable_control;         // Power, measure, wait, mux start
    logic [7:0] wait_time;              // Gap length in wait units, less one

    // Bus data phase capture
    logic       dp_write;               // Write data phase pending
    logic [7:0] dp_addr;                // Address of pending write

    // Synchronisers for the two sync sources
    logic [1:0] sync_pin_ff;            // Dedicated pin chain
    logic [1:0] sync_irq_ff;            // Irq pin chain
    logic       sync_prev;              // Previous selected sync level

    // Timers
    // Busy outputs of the sequencer timers stay open: the state shows it
    logic       integ_done;             // Integration expired
    logic       gap_done;               // Wait gap expired
    logic       mux_tbusy;              // Mux command running
    logic       mux_done;               // Mux command finished

    // Sequencer
    semc_meas_state_t state;            // Current state
    semc_meas_state_t next_state;       // Next state

    // ---------------- Bus decode ----------------
    wire        addr_take   = hsel & htrans[1] & hready;      // Address phase accepted
    wire        rd_take     = addr_take & ~hwrite;            // Read accepted
    wire        wr_mode     = dp_write & (dp_addr == `SEMC_MODE_CONFIG_OFS);
    wire        wr_led      = dp_write & (dp_addr == `SEMC_LED_CONTROL_OFS);
    wire        wr_enable   = dp_write & (dp_addr == `SEMC_ENABLE_CONTROL_OFS);
    wire        wr_wait     = dp_write & (dp_addr == `SEMC_WAIT_TIME_OFS);
    wire [7:0]  wbyte       = hwdata[7:0];                    // Narrow data in low lane

    // Mux start written as one launches the command
    wire        mux_start   = wr_enable & wbyte[`SEMC_MUX_START_BIT];   // [R3]

    // Next register values; used both for storage and read forwarding
    wire [7:0]  next_mode   = wr_mode ? wbyte : mode_config;
    wire [7:0]  next_led    = wr_led ? wbyte : led_control;
    wire [7:0]  next_wait   = wr_wait ? wbyte : wait_time;
    wire [7:0]  en_base     = wr_enable ? wbyte : enable_control;
    // Self-clear on completion; a new start in the same cycle wins
    wire        next_mux    = mux_start ? 1'b1 :
                              (mux_done ? 1'b0 : en_base[`SEMC_MUX_START_BIT]);   // [R4]
    wire [7:0]  next_enable = {en_base[7:5], next_mux, en_base[3:0]};

    // Field views of stored registers
    wire        power_on_bit         = enable_control[`SEMC_POWER_ON_BIT];
    wire        meas_en     = enable_control[`SEMC_MEASURE_EN_BIT];
    wire        wait_en     = enable_control[`SEMC_WAIT_GAP_EN_BIT];
    wire [1:0]  sense_mode  = mode_config[`SEMC_SENSE_MODE_LSB +: 2];
    wire        sync_sel    = mode_config[`SEMC_IRQ_SYNC_SEL_BIT];
    wire        led_ctrl_select     = mode_config[`SEMC_LED_CTRL_SEL_BIT];

    // Status view of block state
    wire [7:0]  status_val  = {3'h0, meas_done, state, mux_tbusy, power_on_bit};

    // Read multiplexer over forwarded values
    wire [7:0]  rd_byte =
        (haddr == `SEMC_MODE_CONFIG_OFS)    ? next_mode   :
        (haddr == `SEMC_LED_CONTROL_OFS)    ? next_led    :
        (haddr == `SEMC_ENABLE_CONTROL_OFS) ? next_enable :
        (haddr == `SEMC_WAIT_TIME_OFS)      ? next_wait   :
        (haddr == `SEMC_STATUS_OFS)         ? status_val  : 8'h00;

    // ---------------- Bus slave ----------------
    // Capture write address phase for the following data phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_write <= addr_take & hwrite;
            dp_addr  <= addr_take ? haddr : dp_addr;
        end
    end

    // Read data, zero wait states, OKAY only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= rd_take ? {24'h00_0000, rd_byte} : hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Register storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_config    <= `SEMC_MODE_CONFIG_RST;
            led_control    <= `SEMC_LED_CONTROL_RST;
            enable_control <= `SEMC_ENABLE_CONTROL_RST;
            wait_time      <= `SEMC_WAIT_TIME_RST;
        end else begin
            mode_config    <= next_mode;
            led_control    <= next_led;
            enable_control <= next_enable;
            wait_time      <= next_wait;
        end
    end

    // ---------------- Sync input ----------------
    // Two-flop chains; only the second stage is read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_pin_ff <= 2'b00;
            sync_irq_ff <= 2'b00;
        end else begin
            sync_pin_ff <= {sync_pin_ff[0], sync_in};
            sync_irq_ff <= {sync_irq_ff[0], irq_pin_in};
        end
    end

    // Irq pin carries sync when selected
    wire        sync_lvl  = sync_sel ? sync_irq_ff[1] : sync_pin_ff[1];   // [R9]

    // Edge history of the selected sync level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_prev <= 1'b0;
        end else begin
            sync_prev <= sync_lvl;
        end
    end

    wire        sync_rise = sync_lvl & ~sync_prev;       // Sync rising edge

    // ---------------- Sequencer ----------------
    // Measurement runs only with power and measure enable
    wire        run        = power_on_bit & meas_en;              // [R6] [R7]
    wire        mode_plain = (sense_mode == SEMC_PLAIN_MEASURE);
    wire        mode_sync_start_mode  = (sense_mode == SEMC_SYNC_START);
    wire        mode_sync_start_stop_mode  = (sense_mode == SEMC_SYNC_START_STOP);
    // Sync-start-stop ends integration on the next sync edge
    wire        integ_end  = mode_sync_start_stop_mode ? sync_rise : integ_done;   // [R10]
    // Where a measurement restarts: at once or on a sync edge
    wire [1:0]  restart_st = mode_plain ? SEMC_INTEG : SEMC_ARM;   // [R10]
    wire        enter_int  = (state == SEMC_IDLE & run & mode_plain) |
                             (state == SEMC_ARM & run & sync_rise) |
                             (state == SEMC_GAP & run & gap_done & mode_plain) |
                             (state == SEMC_INTEG & run & integ_end & ~wait_en & mode_plain);
    wire        enter_gap  = (state == SEMC_INTEG) & run & integ_end & wait_en;   // [R5]
    wire [TW-1:0] gap_load = TW'((32'(wait_time) + 32'd1) * 32'(WAIT_UNIT));

    // Next-state selection
    always_comb begin
        next_state = state;
        case (state)
            SEMC_IDLE: begin
                // Reserved mode never starts
                if (run && (mode_plain || mode_sync_start_mode || mode_sync_start_stop_mode)) begin   // [R10]
                    next_state = mode_plain ? SEMC_INTEG : SEMC_ARM;
                end
            end
            SEMC_ARM: begin
                if (sync_rise) begin
                    next_state = SEMC_INTEG;
                end
            end
            SEMC_INTEG: begin
                if (integ_end) begin
                    // Gap only when enabled, else back to back
                    next_state = wait_en ? SEMC_GAP : semc_meas_state_t'(restart_st);   // [R5]
                end
            end
            SEMC_GAP: begin
                if (gap_done) begin
                    next_state = semc_meas_state_t'(restart_st);
                end
            end
            default: begin
                next_state = SEMC_IDLE;
            end
        endcase
        // Dropping measure enable or power stops at once
        if (!run) begin   // [R6]
            next_state = SEMC_IDLE;
        end
    end

    // State register and end-of-integration pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= SEMC_IDLE;
            meas_done <= 1'b0;
        end else begin
            state     <= next_state;
            meas_done <= (state == SEMC_INTEG) & run & integ_end;
        end
    end

    // Integration timer; unused in sync-start-stop mode
    semc_timer #(.W(TW)) u_integ (
        .clk   (clk),
        .rst_b (rst_b),
        .start (enter_int & ~mode_sync_start_stop_mode),
        .abort (~run),
        .load  (TW'(INTEG_CYCLES)),
        .busy  (),
        .done  (integ_done)
    );

    // Wait gap timer
    semc_timer #(.W(TW)) u_gap (
        .clk   (clk),
        .rst_b (rst_b),
        .start (enter_gap),   // [R5]
        .abort (~run),
        .load  (gap_load),
        .busy  (),
        .done  (gap_done)
    );

    // Sensor mux command timer
    semc_timer #(.W(TW)) u_mux (
        .clk   (clk),
        .rst_b (rst_b),
        .start (mux_start),   // [R3]
        .abort (1'b0),
        .load  (TW'(MUX_CYCLES)),
        .busy  (mux_tbusy),
        .done  (mux_done)     // [R4]
    );

    // ---------------- Pin and status outputs ----------------
    // Registered outputs for pins and observers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_enable    <= 1'b0;
            led_drive_pin <= 1'b0;
            led_drive_oe  <= 1'b0;
            led_current   <= 7'h00;
            irq_pin_out   <= 1'b0;
            irq_pin_oe    <= 1'b0;
            mux_busy      <= 1'b0;
        end else begin
            osc_enable    <= power_on_bit;                                          // [R7]
            led_drive_oe  <= led_ctrl_select;                                      // [R8]
            led_drive_pin <= led_ctrl_select & led_control[`SEMC_LED_ACT_BIT];     // [R8]
            led_current   <= led_ctrl_select ? led_control[6:0] : 7'h00;           // [R8]
            irq_pin_out   <= irq_req;
            irq_pin_oe    <= ~sync_sel;                                    // [R9]
            mux_busy      <= next_mux;                                     // [R4]
        end
    end

    // Sequencer state shown outside
    assign meas_state = state;

endmodule // semc_top

// ### verif/semc_sync_src.sv
// Far-side model: sync pulse source and resolved irq pin level
`timescale 1ns/1ps
module semc_sync_src (
    input  wire logic clk,         // System clock
    input  wire logic rst_b,       // Asynchronous reset, active low
    input  wire logic fire,        // Request one sync pulse
    input  wire logic irq_pin_out, // Level the device drives on the irq pin
    input  wire logic irq_pin_oe,  // Device drives the irq pin
    output logic      sync_in,     // Dedicated sync pin
    output logic      irq_pin_in   // Resolved irq pin level
);
    logic [2:0] left;              // Pulse cycles still to drive

    // Four-cycle pulse so the two-stage synchronizer cannot miss it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            left <= 3'h0;
        end else if (fire) begin
            left <= 3'h4;
        end else if (left != 3'h0) begin
            left <= left - 3'h1;
        end
    end

    // Pulse reaches one pin only, so a wrong sync source stalls the sequencer
    assign sync_in = (left != 3'h0) & irq_pin_oe;
    // Device owns the pin when enabled, else the sync source drives it
    assign irq_pin_in = irq_pin_oe ? irq_pin_out : (left != 3'h0);
endmodule // semc_sync_src

// ### verif/semc_top_assertions.sv
// Port-level assertions for the sensor enable/mode block
`timescale 1ns/1ps
module semc_top_checker #(
    parameter int WAIT_UNIT  = 16, // Cycles per wait step
    parameter int MUX_CYCLES = 32  // Mux command length
) (
    input wire logic                       clk,
    input wire logic                       rst_b,
    input wire logic                       hreadyout,
    input wire logic                       hresp,
    input wire logic                       irq_req,
    input wire logic                       irq_pin_out,
    input wire logic                       irq_pin_oe,
    input wire logic                       led_drive_pin,
    input wire logic                       led_drive_oe,
    input wire logic [6:0]                 led_current,
    input wire logic                       osc_enable,
    input wire logic                       meas_done,
    input wire logic                       mux_busy,
    input wire semc_pkg::semc_meas_state_t meas_state
);
    import semc_pkg::*;
    localparam int MUX_LO = MUX_CYCLES;     // Shortest mux command
    localparam int MUX_HI = MUX_CYCLES + 4; // Longest mux command
    logic [15:0] mux_cnt;                   // Consecutive busy cycles

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Length of the running mux command
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mux_cnt <= 16'h0000;
        end else begin
            mux_cnt <= mux_busy ? mux_cnt + 16'h0001 : 16'h0000;
        end
    end

    property p_bus_okay; hreadyout && !hresp; endproperty
    property p_osc_off; $fell(osc_enable) |-> meas_state == SEMC_IDLE; endproperty
    property p_led_pin; led_drive_pin |-> led_drive_oe; endproperty
    property p_led_cur; !led_drive_oe |-> led_current == 7'h00; endproperty
    property p_irq_copy; irq_pin_oe && $past(irq_pin_oe) |-> irq_pin_out == $past(irq_req); endproperty
    property p_done_pulse; meas_done |=> !meas_done; endproperty
    property p_gap_min; $rose(meas_state == SEMC_GAP) |=> (meas_state == SEMC_GAP)[*8]; endproperty
    property p_mux_hold; $rose(mux_busy) |=> mux_busy[*8]; endproperty
    property p_mux_span; $fell(mux_busy) |-> mux_cnt >= MUX_LO && mux_cnt <= MUX_HI; endproperty

    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
    a_osc_off: assert property (p_osc_off) else $error("sequencer running without oscillator");
    a_led_pin: assert property (p_led_pin) else $error("led on while not controlled");
    a_led_cur: assert property (p_led_cur) else $error("led current while not controlled");
    a_irq_copy: assert property (p_irq_copy) else $error("irq pin not following request");
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    a_gap_min: assert property (p_gap_min) else $error("wait gap too short");
    a_mux_hold: assert property (p_mux_hold) else $error("mux start dropped early");
    a_mux_span: assert property (p_mux_span) else $error("mux start cleared at wrong time");

    c_mux: cover property ($fell(mux_busy));
    c_gap: cover property ($rose(meas_state == SEMC_GAP));
    c_done: cover property (meas_done);
endmodule // semc_top_checker

bind semc_top semc_top_checker #(.WAIT_UNIT(WAIT_UNIT), .MUX_CYCLES(MUX_CYCLES)) u_chk (
    .clk(clk), .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req),
    .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .led_drive_pin(led_drive_pin),
    .led_drive_oe(led_drive_oe), .led_current(led_current), .osc_enable(osc_enable),
    .meas_done(meas_done), .mux_busy(mux_busy), .meas_state(meas_state));

// ### verif/sensor_enable_mode_config_test.sv
// Register-level testbench of the sensor enable/mode block
`timescale 1ns/1ps
module sensor_enable_mode_config_test;
    import semc_pkg::*;
    localparam int MUXC = 20;  // Shortened mux command
    logic clk, rst_b, hsel, hwrite, hreadyout, hresp, fire, sync_in, irq_pin_in, irq_pin_out;
    logic irq_pin_oe, irq_req, led_drive_pin, led_drive_oe, osc_enable, meas_done, mux_busy;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, d;
    logic [6:0] led_current;
    semc_meas_state_t meas_state;
    int fail_count = 0, num_checks = 0, cyc_n = 0, n, t0;

    semc_top #(.INTEG_CYCLES(30), .WAIT_UNIT(16), .MUX_CYCLES(MUXC), .TW(16)) dut (.clk(clk), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sync_in(sync_in),
        .irq_pin_in(irq_pin_in), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .irq_req(irq_req),
        .led_drive_pin(led_drive_pin), .led_drive_oe(led_drive_oe), .led_current(led_current),
        .osc_enable(osc_enable), .meas_done(meas_done), .mux_busy(mux_busy), .meas_state(meas_state));
    semc_sync_src u_src (.clk(clk), .rst_b(rst_b), .fire(fire), .irq_pin_out(irq_pin_out),
        .irq_pin_oe(irq_pin_oe), .sync_in(sync_in), .irq_pin_in(irq_pin_in));

    // 50 MHz clock and a free cycle count
    always #10 clk = ~clk;
    always @(posedge clk) cyc_n <= cyc_n + 1;

    // Verdict and end of run
    task automatic summarize;
        $display("Checks %0d, errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus phase: held until ready is seen at an edge
    task automatic wait_rdy;
        int k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (hreadyout !== 1'b1) begin
            chk("hready", 1, 0);
            summarize();
        end
    endtask

    // Single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus(1'b0, a, 32'h0, v);
    endtask

    // Bounded wait for a sequencer state or a done pulse, at falling edges
    task automatic wait_for(input logic [2:0] s, input int lim, output int k);
        k = 0;
        while (((s[2] && meas_done !== 1'b1) || (!s[2] && meas_state !== s[1:0])) && k < lim) begin
            @(negedge clk);
            k++;
        end
        if (k >= lim) begin
            chk("wait", {29'h0, s}, {29'h0, meas_done, meas_state});
            summarize();
        end
    endtask

    logic [7:0] ra [5] = '{8'h70, 8'h74, 8'h80, 8'h88, 8'h90};  // Writable registers plus one unmapped word
    logic [7:0] rv [5] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00};  // Reset values
    logic [1:0] ms [4] = '{SEMC_INTEG, SEMC_ARM, SEMC_IDLE, SEMC_ARM};  // State a few cycles after start

    initial begin
        {clk, rst_b, hsel, hwrite, fire, irq_req, haddr, htrans, hsize, hwdata} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values, read back and an ignored unmapped write
        wr(8'h90, 32'hff);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], d);
            chk("reset value", {24'h0, rv[i]}, d);
            wr(ra[i], 32'ha5);
            rd(ra[i], d);
            chk("read back", (i == 4) ? 32'h0 : 32'ha5, d);
            wr(ra[i], {24'h0, rv[i]});
        end
        wr(8'h80, 32'h01);  // Power first
        @(negedge clk);
        @(negedge clk);
        chk("osc_enable", 1, osc_enable);
        // LED routing on and off
        wr(8'h74, 32'h85);
        wr(8'h70, 32'h08);
        repeat (3) @(negedge clk);
        chk("led pins", 32'h185, {led_drive_oe, led_drive_pin, led_current});
        wr(8'h70, 32'h00);
        repeat (3) @(negedge clk);
        chk("led pins", 32'h0, {led_drive_oe, led_drive_pin, led_current});
        irq_req <= 1'b1;
        repeat (3) @(negedge clk);
        chk("irq pin", 32'h3, {irq_pin_oe, irq_pin_out});
        @(posedge clk);
        irq_req <= 1'b0;
        // Mux command launch and self-clear
        wr(8'h80, 32'h11);
        t0 = cyc_n;
        rd(8'h80, d);
        chk("mux start", 32'h11, {d[31:1], mux_busy});
        for (n = 0; n < 40 && d[4] !== 1'b0; n++) rd(8'h80, d);
        chk("mux clear time", 1, (cyc_n - t0 >= MUXC) && (cyc_n - t0 <= MUXC + 6));
        chk("enable after mux", 32'h01, d);
        // Every sense mode, reconfigured only while measurement is off
        for (int m = 0; m < 4; m++) begin
            wr(8'h80, 32'h01);
            wr(8'h70, (m == 3) ? 32'h07 : m);  // Last mode takes sync on the irq pin
            wr(8'h80, 32'h03);
            repeat (4) @(negedge clk);
            chk("mode state", ms[m], meas_state);
            chk("irq oe", (m == 3) ? 0 : 1, irq_pin_oe);
            if (m[0]) begin
                fire <= 1'b1;
                @(posedge clk);
                fire <= 1'b0;
                wait_for({1'b0, SEMC_INTEG}, 20, n);
            end
            if (m == 3) begin
                repeat (50) @(negedge clk);
                chk("stop waits for sync", SEMC_INTEG, meas_state);
                rd(8'h60, d);
                chk("alternate data", 0, d);
                fire <= 1'b1;
                @(posedge clk);
                fire <= 1'b0;
            end
            if (m != 2) wait_for(3'h4, 200, n);
        end
        // Wait gap enabled, then disabled
        wr(8'h80, 32'h01);
        wr(8'h70, 32'h00);
        wr(8'h80, 32'h0b);
        wait_for({1'b0, SEMC_GAP}, 200, n);
        for (n = 0; n < 100 && meas_state === SEMC_GAP; n++) @(negedge clk);
        chk("gap length", 1, n >= 16 && n <= 18);
        wr(8'h80, 32'h03);
        wait_for(3'h4, 200, n);
        chk("no gap", SEMC_INTEG, meas_state);
        // Power off in mid-measurement
        wr(8'h80, 32'h00);
        repeat (3) @(negedge clk);
        chk("power off", 32'h0, {osc_enable, meas_state});
        summarize();
    end
endmodule // sensor_enable_mode_config_test
